// ===== hw/sar_consts.svh
// Constants for the successive-approximation converter control
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH
`define CLK_PERIOD_NS 40
`define CONV_CLOCKS 64
`define RESULT_BITS 8
`define STEP_CLOCKS (`CONV_CLOCKS / `RESULT_BITS)
`define STEP_CNT_W 3
`define BIT_IDX_W 3
`define STEP_LAST 3'h7
`define BIT_MSB 3'h7
`define BIT_LSB 3'h0
`define ZERO_BYTE 8'h00
`define DONE_FALL_MAX 8
`define CONV_AGE_W 7
`endif

// ===== hw/sar_pkg.sv
// Types for the successive-approximation converter control
package sar_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_CONV = 4'b0100,
    ST_LOAD = 4'b1000
  } conv_state_t;
  typedef logic [7:0] result_t;
endpackage : sar_pkg

// ===== hw/channel_latch.sv
// Channel select latch and analog selector control
`timescale 1ns/1ps
`include "sar_consts.svh"
module channel_latch
  import sar_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic addr_latch,
  input wire logic sel_a,
  input wire logic sel_b,
  input wire logic sel_c,
  output logic [2:0] channel,
  output logic [7:0] mux_onehot
);
  logic latch_prev_q;
  logic latch_prev_d;
  logic [2:0] chan_q;
  logic [2:0] chan_d;

  always_comb begin
    latch_prev_d = addr_latch;
    chan_d = chan_q;
    if (addr_latch && !latch_prev_q) begin
      chan_d = {sel_c, sel_b, sel_a};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      latch_prev_q <= 1'b0;
      chan_q <= 3'h0;
    end else begin
      latch_prev_q <= latch_prev_d;
      chan_q <= chan_d;
    end
  end

  assign channel = chan_q;
  assign mux_onehot = 8'h01 << chan_q;

  property p_chan_capture;
    @(posedge mclk) disable iff (rst)
      (addr_latch && !latch_prev_q) |=> (channel == $past({sel_c, sel_b, sel_a}));
  endproperty
  a_chan_capture: assert property (p_chan_capture) else $error("channel not captured on latch edge");

  property p_chan_hold;
    @(posedge mclk) disable iff (rst)
      !(addr_latch && !latch_prev_q) |=> $stable(channel);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel changed without latch edge");

  property p_mux_route;
    @(posedge mclk) disable iff (rst)
      mux_onehot[channel] && $onehot(mux_onehot);
  endproperty
  a_mux_route: assert property (p_mux_route) else $error("selector does not match channel");
endmodule : channel_latch

// ===== hw/sar_adc_mux_control.sv
// Successive-approximation converter control with channel selector
// Behaviour
// - Capture channel select lines on rising edge of address latch strobe.
// - Latched value C,B,A picks analog input N for binary value N.
// - Clear approximation register when conversion trigger rises.
// - Start approximation only when conversion trigger falls.
// - A new trigger pulse abandons a running conversion and restarts.
// - Done output goes low within zero to eight clocks after trigger rise.
// - Output data register loads one clock before done rises.
// - Eight approximation steps, one bit each, MSB to LSB.
// - Done fed back to trigger gives continuous conversion.
// - Result is positive-true binary.
// - Data outputs driven only while output enable is high.
`timescale 1ns/1ps
`include "sar_consts.svh"
module sar_adc_mux_control
  import sar_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic addr_latch,
  input wire logic sel_a,
  input wire logic sel_b,
  input wire logic sel_c,
  output logic [7:0] mux_onehot,
  input wire logic conversion_trigger,
  input wire logic comp_above,
  output logic [7:0] trial_code,
  output logic conv_done,
  input wire logic out_enable,
  output logic [7:0] data_out,
  output logic [7:0] data_oe
);
  // ***********************************************
  // Channel selector
  // ***********************************************
  logic [2:0] channel;

  channel_latch i_channel_latch (
    .mclk(mclk),
    .rst(rst),
    .addr_latch(addr_latch),
    .sel_a(sel_a),
    .sel_b(sel_b),
    .sel_c(sel_c),
    .channel(channel),
    .mux_onehot(mux_onehot)
  );

  // ***********************************************
  // Conversion sequencer
  // ***********************************************
  conv_state_t state_q;
  conv_state_t state_d;
  logic trig_prev_q;
  logic trig_prev_d;
  result_t approx_q;
  result_t approx_d;
  result_t result_q;
  result_t result_d;
  logic [`STEP_CNT_W-1:0] step_q;
  logic [`STEP_CNT_W-1:0] step_d;
  logic [`BIT_IDX_W-1:0] bit_q;
  logic [`BIT_IDX_W-1:0] bit_d;
  logic done_q;
  logic done_d;
  logic trig_rise;
  logic trig_fall;

  function automatic result_t bit_mask(input logic [`BIT_IDX_W-1:0] idx);
    bit_mask = result_t'(1) << idx;
  endfunction : bit_mask

  assign trig_rise = conversion_trigger && !trig_prev_q;
  assign trig_fall = !conversion_trigger && trig_prev_q;

  always_comb begin
    state_d = state_q;
    trig_prev_d = conversion_trigger;
    approx_d = approx_q;
    result_d = result_q;
    step_d = step_q;
    bit_d = bit_q;
    done_d = done_q;
    if (trig_rise) begin
      state_d = ST_ARMED;
      approx_d = `ZERO_BYTE;
      done_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_ARMED: begin
          if (trig_fall) begin
            state_d = ST_CONV;
            step_d = '0;
            bit_d = `BIT_MSB;
            approx_d = bit_mask(`BIT_MSB);
          end
        end
        ST_CONV: begin
          step_d = step_q + 1'b1;
          if (step_q == `STEP_LAST) begin
            // Keep trial bit when input is at or above the trial level
            approx_d = comp_above ? approx_q : (approx_q & ~bit_mask(bit_q));
            if (bit_q == `BIT_LSB) begin
              // Result register leads done by one clock
              result_d = approx_d;
              state_d = ST_LOAD;
            end else begin
              bit_d = bit_q - 1'b1;
              approx_d = approx_d | bit_mask(bit_q - 1'b1);
            end
          end
        end
        ST_LOAD: begin
          state_d = ST_IDLE;
          done_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      trig_prev_q <= 1'b0;
      approx_q <= `ZERO_BYTE;
      result_q <= `ZERO_BYTE;
      step_q <= '0;
      bit_q <= `BIT_MSB;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      trig_prev_q <= trig_prev_d;
      approx_q <= approx_d;
      result_q <= result_d;
      step_q <= step_d;
      bit_q <= bit_d;
      done_q <= done_d;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  assign trial_code = approx_q;
  assign conv_done = done_q;
  assign data_out = result_q;
  assign data_oe = {`RESULT_BITS{out_enable}};

  // ***********************************************
  // Checks
  // ***********************************************
  logic [`CONV_AGE_W-1:0] conv_age_q;
  logic [`CONV_AGE_W-1:0] conv_age_d;

  // Clocks spent approximating, for the length check
  always_comb begin
    conv_age_d = '0;
    if (state_q == ST_CONV) begin
      conv_age_d = conv_age_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_age_q <= '0;
    end else begin
      conv_age_q <= conv_age_d;
    end
  end

  sequence s_trig_rise;
    trig_rise;
  endsequence

  sequence s_load_cycle;
    (state_q == ST_LOAD) && !trig_rise;
  endsequence

  sequence s_result_ready;
    (data_out == trial_code) && !conv_done;
  endsequence

  sequence s_conv_start;
    trig_fall && (state_q == ST_ARMED);
  endsequence

  property p_clear_on_rise;
    @(posedge mclk) disable iff (rst)
      s_trig_rise |=> (approx_q == `ZERO_BYTE);
  endproperty
  a_clear_on_rise: assert property (p_clear_on_rise) else $error("register not cleared on trigger rise");

  property p_wait_fall;
    @(posedge mclk) disable iff (rst)
      (state_q == ST_ARMED && conversion_trigger) |=> (state_q == ST_ARMED);
  endproperty
  a_wait_fall: assert property (p_wait_fall) else $error("conversion began while trigger high");

  property p_restart;
    @(posedge mclk) disable iff (rst)
      (state_q == ST_CONV && trig_rise) |=> (state_q == ST_ARMED && !conv_done);
  endproperty
  a_restart: assert property (p_restart) else $error("running conversion not abandoned");

  property p_done_fall;
    @(posedge mclk) disable iff (rst)
      s_trig_rise |-> ##[0:8] !conv_done;
  endproperty
  a_done_fall: assert property (p_done_fall) else $error("done did not fall in time");

  property p_load_before_done;
    @(posedge mclk) disable iff (rst)
      s_load_cycle |-> s_result_ready ##1 conv_done;
  endproperty
  a_load_before_done: assert property (p_load_before_done) else $error("result not loaded with done");

  property p_conv_length;
    @(posedge mclk) disable iff (rst)
      s_conv_start ##1 (!trig_rise) [*8] |=> (bit_q == 3'h6);
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("step length not eight clocks");

  property p_done_time;
    @(posedge mclk) disable iff (rst)
      $rose(conv_done) |-> ($past(conv_age_q) == `CONV_CLOCKS);
  endproperty
  a_done_time: assert property (p_done_time) else $error("conversion not 64 clocks");

  property p_done_low;
    @(posedge mclk) disable iff (rst)
      (state_q == ST_CONV) |-> !conv_done;
  endproperty
  a_done_low: assert property (p_done_low) else $error("done high during conversion");

  property p_oe;
    @(posedge mclk) disable iff (rst)
      (data_oe == {8{out_enable}});
  endproperty
  a_oe: assert property (p_oe) else $error("output enable mismatch");
endmodule : sar_adc_mux_control

// ===== tb/analog_front_model.sv
// Comparator and analog input model
`timescale 1ns/1ps
module analog_front_model (
  input wire logic [7:0] mux_onehot,
  input wire logic [7:0] trial_code,
  input wire logic [63:0] levels,
  output logic comp_above
);
  // Selected level against trial code
  always_comb begin
    comp_above = 1'b0;
    for (int n = 0; n < 8; n++) begin
      if (mux_onehot[n]) begin
        comp_above = (levels[8*n +: 8] >= trial_code);
      end
    end
  end
endmodule : analog_front_model

// ===== tb/sar_adc_mux_control_test.sv
// Testbench for the converter control
`timescale 1ns/1ps
module sar_adc_mux_control_test;
  import sar_pkg::*;
  logic mclk = 0, rst = 1, addr_latch = 0, sel_a = 0, sel_b = 0, sel_c = 0;
  logic trig_r = 0, free_run = 0, out_enable = 0, comp_above, conv_done;
  logic [7:0] mux_onehot, trial_code, data_oe;
  result_t data_out, prev_data;
  logic [63:0] levels = 64'h3c01_7f80_5aa5_ff00;
  wire logic conversion_trigger = free_run ? conv_done : trig_r;
  int error_cnt = 0, tests_run = 0, n;
  always #20 mclk = ~mclk;
  sar_adc_mux_control i_sar_adc_mux_control (.mclk(mclk), .rst(rst), .addr_latch(addr_latch),
    .sel_a(sel_a), .sel_b(sel_b), .sel_c(sel_c), .mux_onehot(mux_onehot),
    .conversion_trigger(conversion_trigger), .comp_above(comp_above), .trial_code(trial_code),
    .conv_done(conv_done), .out_enable(out_enable), .data_out(data_out), .data_oe(data_oe));
  analog_front_model i_analog_front_model (.mux_onehot(mux_onehot), .trial_code(trial_code),
    .levels(levels), .comp_above(comp_above));
  task test_done;
    $display("Counts: tests=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task select(input int ch);
    @(negedge mclk);
    {sel_c, sel_b, sel_a} = ch[2:0];
    addr_latch = 1;
    @(negedge mclk);
    addr_latch = 0;
    {sel_c, sel_b, sel_a} = ~ch[2:0];
    repeat (2) @(negedge mclk);
    chk(mux_onehot, 8'h01 << ch);
  endtask : select
  task start_conv;
    @(negedge mclk);
    trig_r = 1;
    repeat (3) begin
      @(negedge mclk);
      chk(trial_code, 8'h00);
      chk({7'h00, conv_done}, 8'h00);
    end
    trig_r = 0;
  endtask : start_conv
  task wait_level(input logic lvl);
    n = 0;
    while (conv_done !== lvl) begin
      prev_data = data_out;
      @(negedge mclk);
      n++;
      if (n > 200) begin
        error_cnt++;
        test_done();
      end
    end
  endtask : wait_level
  task finish_conv(input int ch);
    wait_level(1);
    chk(n[7:0], 8'h42);
    chk(prev_data, levels[8*ch +: 8]);
    chk(data_out, levels[8*ch +: 8]);
    repeat (4) @(negedge mclk);
    chk({7'h00, conv_done}, 8'h01);
  endtask : finish_conv
  task free_running;
    start_conv();
    finish_conv(3);
    free_run = 1;
    repeat (2) begin
      wait_level(0);
      wait_level(1);
      chk(data_out, levels[31:24]);
    end
    @(negedge mclk);
    free_run = 0;
  endtask : free_running
  task output_gate;
    @(negedge mclk);
    out_enable = 1;
    #1 chk(data_oe, 8'hff);
    @(negedge mclk);
    out_enable = 0;
    #1 chk(data_oe, 8'h00);
  endtask : output_gate
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (16) @(negedge mclk);
    chk({7'h00, conv_done}, 8'h00);
    chk(data_out, 8'h00);
    chk(mux_onehot, 8'h01);
    rst = 0;
    for (int c = 0; c < 8; c++) begin
      select(c);
      start_conv();
      finish_conv(c);
    end
    select(1);
    start_conv();
    repeat (20) @(negedge mclk);
    select(0);
    start_conv();
    finish_conv(0);
    select(3);
    free_running();
    output_gate();
    test_done();
  end
endmodule : sar_adc_mux_control_test
